// [rtl/iox_pkg.sv]
// Shared constants and carrier types for the I/O expander
package iox_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_NS   = 8;
    localparam int SPIKE_NS = 50;
    // Least time, so round up to whole cycles
    localparam int FILT_CYC = (SPIKE_NS + CLK_NS - 1) / CLK_NS;
    localparam int FILT_W   = 3;
    localparam logic [FILT_W-1:0] FILT_LAST = FILT_W'(FILT_CYC - 1);
    localparam logic [3:0] INIT_CYC  = 4'(FILT_CYC + 3);

    // ------------------------------------------------------------
    // Synchroniser vector layout
    // ------------------------------------------------------------
    localparam int SYNC_W    = 13;
    localparam int SCL_BIT   = 0;
    localparam int SDA_BIT   = 1;
    localparam int PIN_LSB   = 2;
    localparam int STRAP_LSB = 10;
    localparam logic [SYNC_W-1:0] SYNC_RST = 13'h03ff;

    // ------------------------------------------------------------
    // Slave address and command byte
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_HI   = 4'h4;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [1:0] SEL_IN    = 2'h0;
    localparam logic [1:0] SEL_OUT   = 2'h1;
    localparam logic [1:0] SEL_POL   = 2'h2;
    localparam logic [1:0] SEL_CFG   = 2'h3;

    // ------------------------------------------------------------
    // Register reset values
    // ------------------------------------------------------------
    localparam logic [7:0] OUT_RST = 8'hff;
    localparam logic [7:0] POL_RST = 8'h00;
    localparam logic [7:0] CFG_RST = 8'hff;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE      = 4'h0,
        ST_ADDR      = 4'h1,
        ST_ADDR_ACK  = 4'h2,
        ST_CMD       = 4'h3,
        ST_CMD_ACK   = 4'h4,
        ST_WDATA     = 4'h5,
        ST_WDATA_ACK = 4'h6,
        ST_RDATA     = 4'h7,
        ST_RDATA_ACK = 4'h8
    } iox_state_t;

    typedef struct packed {
        logic [7:0] hs;
        logic [7:0] ls;
        logic [7:0] o;
        logic [7:0] oe;
    } iox_pin_drv_t;

endpackage : iox_pkg

// [rtl/iox_sync.sv]
// Two-flop synchroniser with per-bit spike filter
`timescale 1ns/100ps
`default_nettype none
module iox_sync
    import iox_pkg::*;
#(
    parameter int              W   = SYNC_W,
    parameter logic [W-1:0]    RST = SYNC_RST
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         reset,
    // Raw and filtered levels
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    typedef struct packed {
        logic [W-1:0]             s1;
        logic [W-1:0]             s2;
        logic [W-1:0]             q;
        logic [W-1:0][FILT_W-1:0] cnt;
    } iox_sync_st_t;

    iox_sync_st_t st_reg;
    iox_sync_st_t st_next;

    // ------------------------------------------------------------
    // Filter: level must hold past the spike time
    // ------------------------------------------------------------
    always_comb begin
        st_next    = st_reg;
        st_next.s1 = din;
        st_next.s2 = st_reg.s1;
        for (int i = 0; i < W; i++) begin
            if (st_reg.s2[i] == st_reg.q[i]) begin
                st_next.cnt[i] = '0;
            end else if (st_reg.cnt[i] == FILT_LAST) begin
                st_next.q[i]   = st_reg.s2[i];
                st_next.cnt[i] = '0;
            end else begin
                st_next.cnt[i] = st_reg.cnt[i] + 3'h1;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_reg <= '{s1: RST, s2: RST, q: RST, cnt: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign dout = st_reg.q;

    property p_filter_settle;
        @(posedge clk) disable iff (reset)
        (st_reg.q[0] != $past(st_reg.q[0]))
            |-> ($past(st_reg.cnt[0]) == FILT_LAST);
    endproperty
    a_filter_settle: assert property (p_filter_settle)
        else $error("scl level passed filter too early");

endmodule : iox_sync
`default_nettype wire

// [rtl/iox_pin_drv.sv]
// Port pin drivers and polarity-corrected input value
`timescale 1ns/100ps
`default_nettype none
module iox_pin_drv
    import iox_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Register values
    input  wire logic [7:0] cfg,
    input  wire logic [7:0] outp,
    input  wire logic [7:0] pol,
    // Filtered pin levels
    input  wire logic [7:0] pins,
    output logic      [7:0] in_val,
    // Pin drive
    output iox_pin_drv_t    drv
);

    iox_pin_drv_t drv_reg;
    iox_pin_drv_t drv_next;

    // ------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------
    always_comb begin
        drv_next.oe = ~cfg;
        drv_next.o  = outp;
        drv_next.hs = ~cfg & outp;
        drv_next.ls = ~cfg & ~outp;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            drv_reg <= '0;
        end else begin
            drv_reg <= drv_next;
        end
    end

    assign drv    = drv_reg;
    assign in_val = pins ^ pol;

    property p_input_hiz;
        @(posedge clk) disable iff (reset)
        ##1 ((drv_reg.hs | drv_reg.ls) & $past(cfg)) == 8'h00;
    endproperty
    a_input_hiz: assert property (p_input_hiz)
        else $error("driver on for an input pin");

    property p_output_one_side;
        @(posedge clk) disable iff (reset)
        ##1 (drv_reg.hs ^ drv_reg.ls) == ~$past(cfg);
    endproperty
    a_output_one_side: assert property (p_output_one_side)
        else $error("output pin lacks exactly one driver");

endmodule : iox_pin_drv
`default_nettype wire

// [rtl/iox_expander.sv]
// Two-wire slave 8-bit I/O expander with change alert
// Function
// - Alert low while input pin differs snapshot
// - Rising or falling input edge raises alert
// - Alert clears on return or input read
// - Read clears alert at preceding ack edge
// - Changes after clearing are signalled again
// - Other slaves' traffic leaves alert untouched
// - Output-mode pins never raise the alert
// - Output-to-input switch may alert at once
// - Alert output is open-drain, never high
// - Input pins have both drivers off
// - Output pins drive side chosen by latch
// - Reset loads defaults and idles slave
// - All pins inputs after power-up
// - Input value inverted where polarity set
// - Every register readable over the bus
// - Three straps set low address bits
// - Four 8-bit registers, bit per pin
// - Slave address is 0100 plus straps
// - Command low bits select the register
// - Selected register kept until new command
// - Direction 1 is input, 0 output
`timescale 1ns/100ps
`default_nettype none
module iox_expander
    import iox_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Two-wire bus
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    // Address straps
    input  wire logic       addr_strap_0,
    input  wire logic       addr_strap_1,
    input  wire logic       addr_strap_2,
    // Port pins
    input  wire logic [7:0] io_pins_in,
    output logic      [7:0] io_pins_out,
    output logic      [7:0] io_pins_oe,
    output logic      [7:0] high_side_driver,
    output logic      [7:0] low_side_driver,
    // Change alert, open-drain
    output logic            int_n_out,
    output logic            int_n_oe
);

    typedef struct packed {
        iox_state_t state;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic [7:0] tx;
        logic       rw;
        logic [1:0] sel;
        logic [7:0] outp;
        logic [7:0] pol;
        logic [7:0] cfg;
        logic [7:0] snap;
        logic       alert;
        logic       init;
        logic [3:0] initc;
        logic       drv;
        logic       scl_d;
        logic       sda_d;
    } iox_st_t;
    iox_st_t           st_reg;
    iox_st_t           st_next;
    logic [SYNC_W-1:0] filt;
    logic [7:0]        pins;
    logic [7:0]        in_val;
    logic [2:0]        strap;
    logic              scl, sda;
    logic              scl_rise, scl_fall;
    logic              start_det, stop_det, read_load;
    iox_pin_drv_t      pdrv;
    // One clock domain, so all checks share clock and reset
    default clocking cb_chk @(posedge clk); endclocking
    default disable iff (reset);

    // ------------------------------------------------------------
    // Input conditioning
    // ------------------------------------------------------------
    iox_sync #(.W (SYNC_W), .RST (SYNC_RST)) u_sync (
        .clk   (clk),
        .reset (reset),
        .din   ({addr_strap_2, addr_strap_1, addr_strap_0,
                 io_pins_in, sda_in, scl_in}),
        .dout  (filt)
    );

    assign scl   = filt[SCL_BIT];
    assign sda   = filt[SDA_BIT];
    assign pins  = filt[PIN_LSB +: 8];
    assign strap = filt[STRAP_LSB +: 3];
    assign scl_rise  = scl & ~st_reg.scl_d;
    assign scl_fall  = ~scl & st_reg.scl_d;
    // Data edges only count while the clock stays high
    assign start_det = scl & st_reg.scl_d & st_reg.sda_d & ~sda;
    assign stop_det  = scl & st_reg.scl_d & ~st_reg.sda_d & sda;

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    iox_pin_drv u_pin_drv (
        .clk    (clk),
        .reset  (reset),
        .cfg    (st_reg.cfg),
        .outp   (st_reg.outp),
        .pol    (st_reg.pol),
        .pins   (pins),
        .in_val (in_val),
        .drv    (pdrv)
    );

    // ------------------------------------------------------------
    // Register read multiplexer
    // ------------------------------------------------------------
    function automatic logic [7:0] reg_mux(input logic [1:0] sel,
        input logic [7:0] inv, outp, pol, cfg);
        case (sel)
            SEL_IN:  return inv;
            SEL_OUT: return outp;
            SEL_POL: return pol;
            default: return cfg;
        endcase
    endfunction : reg_mux

    // ------------------------------------------------------------
    // Slave state machine
    // ------------------------------------------------------------
    always_comb begin
        st_next       = st_reg;
        st_next.scl_d = scl;
        st_next.sda_d = sda;
        read_load     = 1'b0;
        // Snapshot tracks pins until the filter has settled
        if (!st_reg.init) begin
            st_next.initc = st_reg.initc + 4'h1;
            st_next.snap  = pins;
            if (st_reg.initc == INIT_CYC) begin
                st_next.init = 1'b1;
            end
        end

        case (st_reg.state)
            ST_ADDR, ST_CMD, ST_WDATA: begin
                if (scl_rise) begin
                    st_next.sh   = {st_reg.sh[6:0], sda};
                    st_next.bitn = st_reg.bitn + 4'h1;
                end else if (scl_fall && st_reg.bitn == BYTE_BITS) begin
                    st_next.bitn = '0;
                    st_next.drv  = 1'b1;
                    if (st_reg.state == ST_ADDR) begin
                        if (st_reg.sh[7:1] == {ADDR_HI, strap}) begin
                            st_next.rw    = st_reg.sh[0];
                            st_next.state = ST_ADDR_ACK;
                        end else begin
                            // Other slave addressed: stay silent
                            st_next.drv   = 1'b0;
                            st_next.state = ST_IDLE;
                        end
                    end else if (st_reg.state == ST_CMD) begin
                        st_next.sel   = st_reg.sh[1:0];
                        st_next.state = ST_CMD_ACK;
                    end else begin
                        // Writes to the input register are ignored
                        case (st_reg.sel)
                            SEL_OUT: st_next.outp = st_reg.sh;
                            SEL_POL: st_next.pol  = st_reg.sh;
                            SEL_CFG: st_next.cfg  = st_reg.sh;
                            default: ;
                        endcase
                        st_next.state = ST_WDATA_ACK;
                    end
                end
            end
            ST_ADDR_ACK: begin
                if (scl_rise && st_reg.rw) begin
                    read_load = 1'b1;
                end
                if (scl_fall) begin
                    if (st_reg.rw) begin
                        st_next.state = ST_RDATA;
                        st_next.drv   = ~st_reg.tx[7];
                    end else begin
                        st_next.state = ST_CMD;
                        st_next.drv   = 1'b0;
                    end
                end
            end
            ST_CMD_ACK, ST_WDATA_ACK: begin
                if (scl_fall) begin
                    st_next.state = ST_WDATA;
                    st_next.drv   = 1'b0;
                end
            end
            ST_RDATA: begin
                if (scl_rise) begin
                    st_next.tx   = {st_reg.tx[6:0], 1'b0};
                    st_next.bitn = st_reg.bitn + 4'h1;
                end else if (scl_fall) begin
                    if (st_reg.bitn == BYTE_BITS) begin
                        st_next.bitn  = '0;
                        st_next.drv   = 1'b0;
                        st_next.state = ST_RDATA_ACK;
                    end else begin
                        st_next.drv   = ~st_reg.tx[7];
                    end
                end
            end
            ST_RDATA_ACK: begin
                if (scl_rise) begin
                    if (!sda) begin
                        read_load = 1'b1;
                    end else begin
                        st_next.state = ST_IDLE;
                    end
                end else if (scl_fall) begin
                    st_next.state = ST_RDATA;
                    st_next.drv   = ~st_reg.tx[7];
                end
            end
            default: begin
                st_next.drv = 1'b0;
            end
        endcase
        // Clear happens on the ack rise; a pin change on the same
        // edge lands in the snapshot and is not flagged
        if (read_load) begin
            st_next.tx = reg_mux(st_reg.sel, in_val, st_reg.outp,
                                 st_reg.pol, st_reg.cfg);
            if (st_reg.sel == SEL_IN) begin
                st_next.snap = pins;
            end
        end
        // Start and stop win over any byte in flight
        if (start_det) begin
            st_next.state = ST_ADDR;
            st_next.bitn  = '0;
            st_next.drv   = 1'b0;
        end else if (stop_det) begin
            st_next.state = ST_IDLE;
            st_next.drv   = 1'b0;
        end
        // Live compare, so a return to the old level clears too;
        // new direction bits count at once
        st_next.alert = st_next.init
                      & (|((pins ^ st_next.snap) & st_next.cfg));
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_reg <= '{state: ST_IDLE, bitn: '0, sh: '0, tx: '0,
                        rw: 1'b0, sel: SEL_IN, outp: OUT_RST,
                        pol: POL_RST, cfg: CFG_RST, snap: '0,
                        alert: 1'b0, init: 1'b0, initc: '0,
                        drv: 1'b0, scl_d: 1'b1, sda_d: 1'b1};
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign sda_out          = 1'b0;
    assign sda_oe           = st_reg.drv;
    assign int_n_out        = 1'b0;
    assign int_n_oe         = st_reg.alert;
    assign io_pins_out      = pdrv.o;
    assign io_pins_oe       = pdrv.oe;
    assign high_side_driver = pdrv.hs;
    assign low_side_driver  = pdrv.ls;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Direction written in this cycle counts at once
    property p_alert_follows_diff;
        (st_reg.init && !read_load && !start_det
            && (|((pins ^ st_reg.snap) & st_next.cfg)))
            |=> st_reg.alert;
    endproperty
    a_alert_follows_diff: assert property (p_alert_follows_diff)
        else $error("input differs but alert not raised");
    property p_outputs_no_alert;
        int_n_oe |-> (|(($past(pins) ^ st_reg.snap) & st_reg.cfg));
    endproperty
    a_outputs_no_alert: assert property (p_outputs_no_alert)
        else $error("alert raised with no input pin changed");
    property p_alert_open_drain;
        !int_n_out && (int_n_oe == st_reg.alert);
    endproperty
    a_alert_open_drain: assert property (p_alert_open_drain)
        else $error("alert pin driven high");
    property p_reset_defaults;
        $past(reset) |-> (st_reg.cfg == CFG_RST)
            && (st_reg.outp == OUT_RST) && (st_reg.state == ST_IDLE);
    endproperty
    a_reset_defaults: assert property (p_reset_defaults)
        else $error("register not at default after reset");
    property p_ack_only_own_addr;
        (st_reg.state == ST_ADDR && st_next.state == ST_ADDR_ACK)
            |-> (st_reg.sh[7:1] == {ADDR_HI, strap}) ##1 sda_oe;
    endproperty
    a_ack_only_own_addr: assert property (p_ack_only_own_addr)
        else $error("ack given to foreign address");
    property p_read_clears;
        (read_load && st_reg.sel == SEL_IN && !start_det)
            |=> (st_reg.snap == $past(pins))
            && (st_reg.tx == $past(in_val));
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("input read did not refresh snapshot");
    property p_foreign_traffic;
        (st_reg.state == ST_IDLE && st_reg.init)
            |=> $stable(st_reg.snap) && $stable(st_reg.outp)
            && $stable(st_reg.cfg);
    endproperty
    a_foreign_traffic: assert property (p_foreign_traffic)
        else $error("idle bus traffic changed state");
    property p_select_kept;
        (st_reg.state != ST_CMD) |=> $stable(st_reg.sel);
    endproperty
    a_select_kept: assert property (p_select_kept)
        else $error("register selection changed outside command");
    property p_power_up_inputs;
        $past(reset) |-> ##1 (io_pins_oe == 8'h00);
    endproperty
    a_power_up_inputs: assert property (p_power_up_inputs)
        else $error("pin driven after power-up");
endmodule : iox_expander
`default_nettype wire

// [verif/iox_i2c_master.sv]
// Two-wire bus master model for the expander bench
`timescale 1ns/100ps
`default_nettype none
module iox_i2c_master #(
    parameter int HALF = 24
) (
    // Clock
    input  wire logic clk,
    // Bus lines, sda_low pulls the data line down
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end
    // Half period well above the spike filter, else bits vanish
    task automatic hold();
        repeat (HALF) @(negedge clk);
    endtask : hold
    // Also the repeated start; bus is high before it
    task automatic start();
        sda_low = 1'b0;
        hold();
        scl = 1'b1;
        hold();
        sda_low = 1'b1;
        hold();
        scl = 1'b0;
    endtask : start
    task automatic stop();
        repeat (4) @(negedge clk);
        sda_low = 1'b1;
        hold();
        scl = 1'b1;
        hold();
        sda_low = 1'b0; // Both lines left high
        hold();
    endtask : stop
    // Nine bits, MSB first; data moves only while scl is low
    task automatic xfer(input logic [7:0] v, input logic ack_in,
                        output logic [7:0] r, output logic ack_seen);
        logic [8:0] tx;
        logic [8:0] rx;
        tx = {v, ack_in};
        for (int i = 8; i >= 0; i--) begin
            repeat (4) @(negedge clk);
            sda_low = ~tx[i];
            hold();
            scl = 1'b1;
            hold();
            rx[i] = sda;
            scl = 1'b0;
        end
        r = rx[8:1];
        ack_seen = rx[0];
    endtask : xfer
    task automatic wr_reg(input logic [6:0] a, input logic [7:0] cmd,
                          input logic [7:0] d, output logic nak);
        logic [7:0] r;
        logic       k0, k1, k2;
        start();
        xfer({a, 1'b0}, 1'b1, r, k0); // Address then selector
        xfer(cmd, 1'b1, r, k1);
        xfer(d, 1'b1, r, k2);
        stop();
        nak = k0 | k1 | k2;
    endtask : wr_reg
    // Last byte refused by master so the slave lets go
    task automatic rd_cur(input logic [6:0] a, output logic [7:0] d,
                          output logic nak);
        logic [7:0] r;
        logic       k1;
        start();
        xfer({a, 1'b1}, 1'b1, r, nak);
        xfer(8'hff, 1'b1, d, k1);
        stop();
    endtask : rd_cur
    task automatic rd_reg(input logic [6:0] a, input logic [7:0] cmd,
                          output logic [7:0] d, output logic nak);
        logic [7:0] r;
        logic       k0, k1, k2;
        start();
        xfer({a, 1'b0}, 1'b1, r, k0); // Select, re-address
        xfer(cmd, 1'b1, r, k1);
        rd_cur(a, d, k2);
        nak = k0 | k1 | k2;
    endtask : rd_reg
endmodule : iox_i2c_master
`default_nettype wire

// [verif/tb.sv]
// Self-checking bench for the two-wire I/O expander
`timescale 1ns/100ps
`default_nettype none
module tb;
    import iox_pkg::*;
    localparam logic [6:0] DEV = {ADDR_HI, 3'h5};
    logic       clk, reset, scl, m_low, sda_line, sda_oe, sda_out;
    logic       int_n_out, int_n_oe, nak;
    logic [2:0] strap;
    logic [7:0] ext, pins, p_out, p_oe, hs, ls, d;
    int         n_errors, num_checks;
    // Open drain bus with pull-up; driven port pins win over ext
    assign sda_line = ~m_low & (sda_oe ? sda_out : 1'b1);
    assign pins = (p_oe & p_out) | (~p_oe & ext);
    iox_expander dut_u (.clk(clk), .reset(reset), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .addr_strap_0(strap[0]), .addr_strap_1(strap[1]),
        .addr_strap_2(strap[2]), .io_pins_in(pins), .io_pins_out(p_out),
        .io_pins_oe(p_oe), .high_side_driver(hs), .low_side_driver(ls),
        .int_n_out(int_n_out), .int_n_oe(int_n_oe));
    iox_i2c_master master_u (.clk(clk), .sda(sda_line), .scl(scl),
        .sda_low(m_low));
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : complete_run
    task automatic chk(input string w, input logic [7:0] e, g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s exp %h got %h", w, e, g);
        end
    endtask : chk
    task automatic wr(input logic [1:0] s, input logic [7:0] v);
        master_u.wr_reg(DEV, {6'h00, s}, v, nak);
        chk("wr nak", 8'h00, {7'h00, nak});
    endtask : wr
    task automatic rd(input logic [1:0] s, input logic [7:0] e);
        master_u.rd_reg(DEV, {6'h00, s}, d, nak);
        chk("rd nak", 8'h00, {7'h00, nak});
        chk("rd data", e, d);
    endtask : rd
    // Bounded wait; a stuck alert ends the run
    task automatic alert(input logic e);
        for (int n = 0; n < 40 && int_n_oe !== e; n++) @(negedge clk);
        chk("alert", {7'h00, e}, {7'h00, int_n_oe});
        if (int_n_oe !== e) complete_run();
    endtask : alert
    task automatic t_reset();
        chk("oe", 8'h00, p_oe);
        chk("drv", 8'h00, hs | ls);
        rd(SEL_CFG, CFG_RST);
        rd(SEL_OUT, OUT_RST);
        rd(SEL_POL, POL_RST);
    endtask : t_reset
    task automatic t_drive();
        wr(SEL_OUT, 8'ha5);
        wr(SEL_CFG, 8'h0f);
        chk("oe", 8'hf0, p_oe);
        chk("hs", 8'ha0, hs);
        chk("ls", 8'h50, ls);
        master_u.rd_cur(DEV, d, nak);
        chk("kept sel", 8'h0f, d);
    endtask : t_drive
    task automatic t_alert();
        wr(SEL_POL, 8'h03);
        rd(SEL_IN, 8'haf);
        ext = 8'h3d;
        alert(1'b1);
        master_u.wr_reg({ADDR_HI, 3'h0}, 8'h01, 8'h00, nak);
        chk("foreign", 8'h01, {7'h00, nak});
        chk("alert kept", 8'h01, {7'h00, int_n_oe});
        ext = 8'h3c;
        alert(1'b0);
        ext = 8'h3d;
        alert(1'b1);
        master_u.rd_cur(DEV, d, nak);
        chk("in", 8'hae, d);
        alert(1'b0);
        // Output pin 7 really falls; ext cannot move a driven pin
        wr(SEL_OUT, 8'h25);
        repeat (40) @(negedge clk);
        chk("out pin", 8'h00, {7'h00, int_n_oe});
        chk("od", 8'h00, {7'h00, int_n_out});
        ext = 8'h3d;
        wr(SEL_CFG, 8'h8f);
        alert(1'b1);
    endtask : t_alert
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        reset = 1'b1;
        ext = 8'h3c;
        strap = 3'h5;
        n_errors = 0;
        num_checks = 0;
        repeat (12) @(negedge clk);
        reset = 1'b0;
        repeat (20) @(negedge clk);
        t_reset();
        t_drive();
        t_alert();
        complete_run();
    end
endmodule : tb
`default_nettype wire
